// ---- design/tpc_band_spread.sv ----
/*
   Spreads a number of bands evenly over a measured span: each step
   advances a fractional accumulator, the band index counts wraps.
   Assumes restart and step come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tpc_band_spread #(
   parameter int BANDS  = 256,
   parameter int SPAN_W = 12,
   parameter int IDX_W  = 8
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // position
   input  wire logic              restart,
   input  wire logic              step,
   input  wire logic [SPAN_W-1:0] span,
   // band of the current position
   output logic      [IDX_W-1:0]  idx
);

   localparam int               SUM_W = SPAN_W + 2;
   localparam logic [SPAN_W:0]  INC   = (SPAN_W+1)'(BANDS);
   localparam logic [IDX_W-1:0] LAST  = IDX_W'(BANDS - 1);
   localparam logic [SUM_W-1:0] TOP   = SUM_W'(BANDS - 1);

   if (BANDS < 2 || BANDS > (1 << IDX_W) || BANDS >= (1 << SPAN_W))
   begin : g_bad
      $error("tpc_band_spread: BANDS does not fit IDX_W or SPAN_W");
   end

   logic [SPAN_W:0]  acc;
   logic [SPAN_W:0]  sum;
   logic [SPAN_W:0]  divisor;
   logic [SPAN_W:0]  whole;
   logic [SPAN_W:0]  frac;
   logic             carry;
   logic [SUM_W-1:0] nextIdx;

   // more bands than positions: one step may cross several bands
   assign divisor = (span == '0) ? (SPAN_W+1)'(1) : {1'b0, span};
   assign whole   = INC / divisor;
   assign frac    = INC % divisor;
   assign sum     = acc + frac;
   assign carry   = (sum >= divisor);
   assign nextIdx = SUM_W'(idx) + SUM_W'(whole) + SUM_W'(carry);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= '0;
         idx <= '0;
      end else if (restart) begin
         acc <= '0;
         idx <= '0;
      end else if (step) begin
         acc <= carry ? sum - divisor : sum;
         idx <= (nextIdx > TOP) ? LAST : nextIdx[IDX_W-1:0];
      end
   end

endmodule

`default_nettype wire

// ---- design/tpc_pattern_ctrl.sv ----
/*
   Video test pattern control: APB register file, pattern selection,
   auto-scrolling and the pixel substitution in front of the serializer.
   Assumes video timing and data arrive on clk (the pixel clock) from
   logic in the same domain and that the APB master is on clk too.
*/
// Register access over APB was left to the implementer.
// Function
// - generate only while enable set; off after reset
// - select field bits 7:4, reset 0x10
// - select ignored while auto-scrolling
// - scaled bands spread evenly over active region
// - codes 0-2 checker, white/black, black/white
// - codes 3-5 red, green, blue colour pairs
// - codes 6-9 horizontal ramps white, red, green, blue
// - codes 10-13 vertical ramps white, red, green, blue
// - code 14 custom colour from three levels
// - code 15 multi-colour panel band pattern
// - colour bars bit 2 overrides select
// - bit 1 reverses panel band order
`timescale 1ns/10ps
`default_nettype none

`include "tpc_consts.svh"

module tpc_pattern_ctrl
   import tpc_pkg::*;
#(
   parameter int SPAN_W        = 12,
   parameter int SCROLL_FRAMES = `TPC_SCROLL_FRAMES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // incoming video
   input  wire logic        vidDe,
   input  wire logic        vidHs,
   input  wire logic        vidVs,
   input  wire tpc_pixel_t  vidData,
   // video toward the serializer
   output logic             outDe,
   output logic             outHs,
   output logic             outVs,
   output tpc_pixel_t       outData
);

   if (SPAN_W < 9 || SPAN_W > 16 || SCROLL_FRAMES < 1 ||
       SCROLL_FRAMES > 255) begin : g_bad
      $error("tpc_pattern_ctrl: parameter out of range");
   end

   // registers
   logic [7:0] ctrl_r;
   logic [7:0] cfg_r;
   logic [7:0] customRed_r;
   logic [7:0] customGreen_r;
   logic [7:0] customBlue_r;

   // bus decode
   logic        accessPhase;
   logic        wrDone;
   logic        addrHit;
   logic [31:0] rdValue;

   // timing
   logic              deD_r;
   logic              vsD_r;
   logic              lineEnd;
   logic              frameStart;
   logic [SPAN_W-1:0] activeWidth;
   logic [SPAN_W-1:0] activeHeight;
   logic              xBit_r;
   logic              yBit_r;

   // band indices
   logic [7:0] hLevel;
   logic [7:0] vLevel;
   logic [2:0] hBar;
   logic [1:0] vBand;

   // selection
   logic [7:0] frameCnt_r;
   logic [3:0] scrollCode_r;
   tpc_pat_e   patCode;
   tpc_pixel_t patPixel;
   tpc_pixel_t barPixel;
   tpc_pixel_t panelPixel;
   logic [2:0] rampMask;
   logic [7:0] rampLevel;
   logic       genEn;
   logic       autoScroll;
   logic       invert;

   assign genEn      = ctrl_r[`TPC_CTRL_EN];
   assign autoScroll = cfg_r[`TPC_CFG_SCROLL];
   assign invert     = cfg_r[`TPC_CFG_INV];

   // ---- APB: one wait state, write at the completing edge, read data registered at the edge that raises pready
   assign accessPhase = psel & penable;
   assign wrDone      = accessPhase & pready & pwrite;

   always_comb begin
      addrHit = 1'b1;
      rdValue = 32'h0000_0000;
      if (paddr == `TPC_OFF_CTRL) begin
         rdValue = {24'h000000, ctrl_r};
      end else if (paddr == `TPC_OFF_RED) begin
         rdValue = {24'h000000, customRed_r};
      end else if (paddr == `TPC_OFF_GREEN) begin
         rdValue = {24'h000000, customGreen_r};
      end else if (paddr == `TPC_OFF_BLUE) begin
         rdValue = {24'h000000, customBlue_r};
      end else if (paddr == `TPC_OFF_CFG) begin
         rdValue = {24'h000000, cfg_r};
      end else if (paddr == `TPC_OFF_STATUS) begin
         rdValue = {24'h000000, 4'(patCode), 3'h0, genEn};
      end else if (paddr == `TPC_OFF_SPAN) begin
         rdValue = {(16)'(activeHeight), (16)'(activeWidth)};
      end else begin
         addrHit = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (accessPhase && !pready) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h0000_0000 : rdValue;
         pslverr <= ~addrHit;
      end else begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // control register, reserved bit 3 stays zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `TPC_CTRL_RST;
      end else if (wrDone && paddr == `TPC_OFF_CTRL) begin
         ctrl_r <= pwdata[7:0] & `TPC_CTRL_WMASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= `TPC_CFG_RST;
      end else if (wrDone && paddr == `TPC_OFF_CFG) begin
         cfg_r <= pwdata[7:0] & `TPC_CFG_WMASK;
      end
   end

   // custom colour levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         customRed_r   <= `TPC_CUSTOM_RST;
         customGreen_r <= `TPC_CUSTOM_RST;
         customBlue_r  <= `TPC_CUSTOM_RST;
      end else if (wrDone) begin
         if (paddr == `TPC_OFF_RED) begin
            customRed_r <= pwdata[7:0];
         end
         if (paddr == `TPC_OFF_GREEN) begin
            customGreen_r <= pwdata[7:0];
         end
         if (paddr == `TPC_OFF_BLUE) begin
            customBlue_r <= pwdata[7:0];
         end
      end
   end

   // ---- video timing edges and checker parity
   assign lineEnd    = deD_r & ~vidDe;
   assign frameStart = vidVs & ~vsD_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         deD_r <= 1'b0;
         vsD_r <= 1'b0;
      end else begin
         deD_r <= vidDe;
         vsD_r <= vidVs;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xBit_r <= 1'b0;
         yBit_r <= 1'b0;
      end else begin
         xBit_r <= vidDe ? ~xBit_r : 1'b0;
         if (frameStart) begin
            yBit_r <= 1'b0;
         end else if (lineEnd) begin
            yBit_r <= ~yBit_r;
         end
      end
   end

   tpc_span_meter #(
      .SPAN_W (SPAN_W)
   ) u_meter (
      .clk        (clk),
      .rst_n      (rst_n),
      .de         (vidDe),
      .lineEnd    (lineEnd),
      .frameStart (frameStart),
      .width      (activeWidth),
      .height     (activeHeight)
   );

   // bands spread over the measured active region
   tpc_band_spread #(
      .BANDS (256), .SPAN_W (SPAN_W), .IDX_W (8)
   ) u_hLevel (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (~vidDe),
      .step    (vidDe),
      .span    (activeWidth),
      .idx     (hLevel)
   );

   tpc_band_spread #(
      .BANDS (256), .SPAN_W (SPAN_W), .IDX_W (8)
   ) u_vLevel (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (frameStart),
      .step    (lineEnd),
      .span    (activeHeight),
      .idx     (vLevel)
   );

   tpc_band_spread #(
      .BANDS (8), .SPAN_W (SPAN_W), .IDX_W (3)
   ) u_hBar (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (~vidDe),
      .step    (vidDe),
      .span    (activeWidth),
      .idx     (hBar)
   );

   tpc_band_spread #(
      .BANDS (4), .SPAN_W (SPAN_W), .IDX_W (2)
   ) u_vBand (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (frameStart),
      .step    (lineEnd),
      .span    (activeHeight),
      .idx     (vBand)
   );

   // ---- auto-scrolling steps through every code
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frameCnt_r   <= 8'h00;
         scrollCode_r <= 4'h0;
      end else if (!autoScroll) begin
         frameCnt_r   <= 8'h00;
         scrollCode_r <= 4'h0;
      end else if (frameStart) begin
         if (frameCnt_r == 8'(SCROLL_FRAMES - 1)) begin
            frameCnt_r   <= 8'h00;
            scrollCode_r <= scrollCode_r + 4'h1;
         end else begin
            frameCnt_r <= frameCnt_r + 8'h01;
         end
      end
   end

   assign patCode = autoScroll ? tpc_pat_e'(scrollCode_r)
                  : tpc_pat_e'(ctrl_r[`TPC_CTRL_SEL_HI:`TPC_CTRL_SEL_LO]);

   // ---- colour bars and panel bands
   always_comb begin
      case (hBar)
         3'd0:    barPixel = `TPC_WHITE;
         3'd1:    barPixel = `TPC_YELLOW;
         3'd2:    barPixel = `TPC_CYAN;
         3'd3:    barPixel = `TPC_GREEN;
         3'd4:    barPixel = `TPC_MAGENTA;
         3'd5:    barPixel = `TPC_RED;
         3'd6:    barPixel = `TPC_BLUE;
         default: barPixel = `TPC_BLACK;
      endcase
   end

   always_comb begin
      case (vBand ^ {2{ctrl_r[`TPC_CTRL_REV]}})
         2'd0:    panelPixel = `TPC_YELLOW;
         2'd1:    panelPixel = `TPC_CYAN;
         2'd2:    panelPixel = `TPC_BLUE;
         default: panelPixel = `TPC_RED;
      endcase
      if (xBit_r ^ yBit_r) begin
         panelPixel = `TPC_BLACK;
      end
   end

   // ---- pattern choice
   always_comb begin
      rampMask  = 3'b000;
      rampLevel = hLevel;
      case (patCode)
         TPC_H_WHITE: rampMask = 3'b111;
         TPC_H_RED:   rampMask = 3'b100;
         TPC_H_GREEN: rampMask = 3'b010;
         TPC_H_BLUE:  rampMask = 3'b001;
         TPC_V_WHITE: begin
            rampMask  = 3'b111;
            rampLevel = vLevel;
         end
         TPC_V_RED: begin
            rampMask  = 3'b100;
            rampLevel = vLevel;
         end
         TPC_V_GREEN: begin
            rampMask  = 3'b010;
            rampLevel = vLevel;
         end
         TPC_V_BLUE: begin
            rampMask  = 3'b001;
            rampLevel = vLevel;
         end
         default: rampMask = 3'b000;
      endcase
   end

   always_comb begin
      case (patCode)
         TPC_CHECKER:   patPixel = (xBit_r ^ yBit_r) ? `TPC_BLACK
                                                     : `TPC_WHITE;
         TPC_WHITE_BLK: patPixel = `TPC_WHITE;
         TPC_BLK_WHITE: patPixel = `TPC_BLACK;
         TPC_RED_CYAN:  patPixel = `TPC_RED;
         TPC_GRN_MAG:   patPixel = `TPC_GREEN;
         TPC_BLU_YEL:   patPixel = `TPC_BLUE;
         TPC_CUSTOM:    patPixel = {customRed_r, customGreen_r,
                                    customBlue_r};
         TPC_PANEL:     patPixel = panelPixel;
         default: begin
            patPixel = {rampMask[2] ? rampLevel : 8'h00,
                        rampMask[1] ? rampLevel : 8'h00,
                        rampMask[0] ? rampLevel : 8'h00};
         end
      endcase
      if (ctrl_r[`TPC_CTRL_BARS]) begin
         patPixel = barPixel;
      end
   end

   // ---- output stage toward the serializer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outDe   <= 1'b0;
         outHs   <= 1'b0;
         outVs   <= 1'b0;
         outData <= `TPC_BLACK;
      end else begin
         outDe <= vidDe;
         outHs <= vidHs;
         outVs <= vidVs;
         if (genEn && vidDe) begin
            outData <= patPixel ^ {24{invert}};
         end else if (genEn) begin
            outData <= `TPC_BLACK;
         end else begin
            outData <= vidData;
         end
      end
   end

endmodule

`default_nettype wire

// ---- design/tpc_span_meter.sv ----
/*
   Measures the active width and height of the incoming frames.
   Assumes de, lineEnd and frameStart come from the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tpc_span_meter #(
   parameter int SPAN_W = 12
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // video timing
   input  wire logic              de,
   input  wire logic              lineEnd,
   input  wire logic              frameStart,
   // last measured extent
   output logic      [SPAN_W-1:0] width,
   output logic      [SPAN_W-1:0] height
);

   logic [SPAN_W-1:0] pixCnt;
   logic [SPAN_W-1:0] lineCnt;

   // pixels of the running line
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pixCnt <= '0;
         width  <= '0;
      end else if (de) begin
         pixCnt <= pixCnt + 1'b1;
      end else if (lineEnd) begin
         width  <= pixCnt;
         pixCnt <= '0;
      end
   end

   // lines of the running frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lineCnt <= '0;
         height  <= '0;
      end else if (frameStart) begin
         height  <= lineCnt;
         lineCnt <= '0;
      end else if (lineEnd) begin
         lineCnt <= lineCnt + 1'b1;
      end
   end

endmodule

`default_nettype wire

// ---- inc/tpc_consts.svh ----
/*
   Register offsets, field positions, reset values and colour constants
   of the video test pattern control block.
   Assumes inclusion by bare name from the pattern control module.
*/
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH

// byte offsets on the APB bus
`define TPC_OFF_CTRL    8'h64
`define TPC_OFF_RED     8'h68
`define TPC_OFF_GREEN   8'h6C
`define TPC_OFF_BLUE    8'h70
`define TPC_OFF_CFG     8'h74
`define TPC_OFF_STATUS  8'h78
`define TPC_OFF_SPAN    8'h7C

// control register fields
`define TPC_CTRL_EN     0
`define TPC_CTRL_REV    1
`define TPC_CTRL_BARS   2
`define TPC_CTRL_SEL_LO 4
`define TPC_CTRL_SEL_HI 7
`define TPC_CTRL_WMASK  8'hF7
`define TPC_CTRL_RST    8'h10

// configuration register fields
`define TPC_CFG_SCROLL  0
`define TPC_CFG_INV     1
`define TPC_CFG_WMASK   8'h03
`define TPC_CFG_RST     8'h00
`define TPC_CUSTOM_RST  8'h00

// frames shown per pattern while scrolling
`define TPC_SCROLL_FRAMES 60

// pattern colours
`define TPC_BLACK   24'h000000
`define TPC_WHITE   24'hFFFFFF
`define TPC_RED     24'hFF0000
`define TPC_GREEN   24'h00FF00
`define TPC_BLUE    24'h0000FF
`define TPC_YELLOW  24'hFFFF00
`define TPC_CYAN    24'h00FFFF
`define TPC_MAGENTA 24'hFF00FF

`endif

// ---- inc/tpc_pkg.sv ----
/*
   Types of the video test pattern control block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package tpc_pkg;

   typedef logic [23:0] tpc_pixel_t;

   typedef enum logic [3:0] {
      TPC_CHECKER   = 4'b0000,
      TPC_WHITE_BLK = 4'b0001,
      TPC_BLK_WHITE = 4'b0010,
      TPC_RED_CYAN  = 4'b0011,
      TPC_GRN_MAG   = 4'b0100,
      TPC_BLU_YEL   = 4'b0101,
      TPC_H_WHITE   = 4'b0110,
      TPC_H_RED     = 4'b0111,
      TPC_H_GREEN   = 4'b1000,
      TPC_H_BLUE    = 4'b1001,
      TPC_V_WHITE   = 4'b1010,
      TPC_V_RED     = 4'b1011,
      TPC_V_GREEN   = 4'b1100,
      TPC_V_BLUE    = 4'b1101,
      TPC_CUSTOM    = 4'b1110,
      TPC_PANEL     = 4'b1111
   } tpc_pat_e;

endpackage

// ---- verification/tpc_pattern_ctrl_chk.sv ----
/*
   Concurrent checks on the ports of the pattern control block.
   Assumes a bind into tpc_pattern_ctrl and a single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module tpc_pattern_ctrl_chk
   import tpc_pkg::*;
#(
   parameter int SPAN_W        = 12,
   parameter int SCROLL_FRAMES = 60
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // video
   input wire logic        vidDe,
   input wire logic        vidHs,
   input wire logic        vidVs,
   input wire tpc_pixel_t  vidData,
   input wire logic        outDe,
   input wire logic        outHs,
   input wire logic        outVs,
   input wire tpc_pixel_t  outData
);
   logic [7:0] ctrlR;
   logic [1:0] cfgR;
   logic       stR;
   logic       wrHit;
   logic       calm;

   assign wrHit = psel && penable && pready && pwrite && !pslverr;
   assign calm  = stR && cfgR == 2'b00;

   // shadow of the bits that shape the output
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlR <= 8'h10;
         cfgR  <= 2'b00;
      end else if (wrHit && paddr == 8'h64) begin
         ctrlR <= pwdata[7:0] & 8'hF7;
      end else if (wrHit && paddr == 8'h74) begin
         cfgR <= pwdata[1:0];
      end
   end

   // low for one cycle after a register write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stR <= 1'b0;
      end else begin
         stR <= !wrHit;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence

   property p_solid(logic [3:0] code, tpc_pixel_t colour);
      ctrlR[0] && !ctrlR[2] && ctrlR[7:4] == code && calm && vidDe
         |=> outData == colour;
   endproperty

   acc_wait_a: assert property (s_setup |-> !pready ##1 pready)
      else $error("access not answered after one wait state");
   rdy_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   err_map_a: assert property (pready |-> pslverr == !(paddr inside
      {8'h64, 8'h68, 8'h6C, 8'h70, 8'h74, 8'h78, 8'h7C}))
      else $error("pslverr does not match address map");
   ctrl_read_a: assert property (pready && !pwrite && paddr == 8'h64
      |-> prdata == {24'h0, ctrlR}) else $error("control readback wrong");
   sync_follow_a: assert property (outDe == $past(vidDe) &&
      outHs == $past(vidHs) && outVs == $past(vidVs))
      else $error("timing outputs not one cycle behind inputs");
   pass_off_a: assert property (!ctrlR[0] && stR
      |=> outData == $past(vidData)) else $error("disabled not passing");
   gen_blank_a: assert property (ctrlR[0] && stR && !vidDe
      |=> outData == 24'h0) else $error("blanking not black");
   bars_left_a: assert property (ctrlR[0] && ctrlR[2] && calm
      && $rose(vidDe) |=> outData == 24'hFFFFFF)
      else $error("first bar not white");
   white_a: assert property (p_solid(4'h1, 24'hFFFFFF))
      else $error("code 1 not white");
   black_a: assert property (p_solid(4'h2, 24'h000000))
      else $error("code 2 not black");
   red_a: assert property (p_solid(4'h3, 24'hFF0000))
      else $error("code 3 not red");
endmodule

`default_nettype wire

// ---- verification/tpc_pattern_ctrl_tb.sv ----
/*
   Bench of the pattern control block: APB tasks, frames of 16x4 video.
   Assumes the sink model and the checker are compiled beforehand.
*/
`timescale 1ns/10ps
`default_nettype none

module tpc_pattern_ctrl_tb
   import tpc_pkg::*;
;
   logic        clk     = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic        vidDe   = 1'b0;
   logic        vidHs   = 1'b0;
   logic        vidVs   = 1'b0;
   tpc_pixel_t  vidData = 24'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        outDe;
   logic        outHs;
   logic        outVs;
   tpc_pixel_t  outData;
   logic [31:0] rdat;
   logic        rerr;
   int          miscompares = 0;
   int          numChecks   = 0;
   int          cyc         = 0;
   tpc_pixel_t  pairs [2][5] = '{'{24'hFFFFFF, 24'h0, 24'hFF0000,
      24'h00FF00, 24'h0000FF}, '{24'h0, 24'hFFFFFF, 24'h00FFFF,
      24'hFF00FF, 24'hFFFF00}};
   tpc_pixel_t  masks [4] = '{24'hFFFFFF, 24'hFF0000, 24'h00FF00,
      24'h0000FF};
   int          barX [4] = '{0, 3, 13, 15};
   tpc_pixel_t  barC [4] = '{24'hFFFFFF, 24'hFFFF00, 24'h0000FF, 24'h0};

   always #2.5 clk = ~clk;

   tpc_pattern_ctrl #(.SCROLL_FRAMES(1)) u_tpc_pattern_ctrl (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .vidDe(vidDe), .vidHs(vidHs),
      .vidVs(vidVs), .vidData(vidData), .outDe(outDe), .outHs(outHs),
      .outVs(outVs), .outData(outData));

   tpc_video_sink u_tpc_video_sink (.clk(clk), .rst_n(rst_n),
      .de(outDe), .vs(outVs), .data(outData));

   function automatic tpc_pixel_t px(input int i);
      return u_tpc_video_sink.pix[i];
   endfunction

   task automatic chk_reg(input string n, input logic [31:0] e,
                          input logic [31:0] g);
      numChecks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask

   task automatic chk_pix(input string n, input tpc_pixel_t e,
                          input tpc_pixel_t g);
      numChecks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask

   // request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic frame();
      vidVs <= 1'b1;
      repeat (2) @(posedge clk);
      vidVs <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         vidHs <= 1'b1;
         vidData <= 24'hA5A5A5;
         @(posedge clk);
         vidHs <= 1'b0;
         repeat (3) @(posedge clk);
         for (int c = 0; c < 16; c++) begin
            vidDe <= 1'b1;
            vidData <= {8'h5A, 8'(r), 8'(c)};
            @(posedge clk);
         end
         vidDe <= 1'b0;
      end
      repeat (4) @(posedge clk);
   endtask

   // second frame is scaled from the first one's measurement
   task automatic show(input logic [7:0] c);
      wr(8'h64, c);
      frame();
      frame();
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(8'h64);
      chk_reg("ctrl reset", 32'h10, rdat);
      wr(8'h64, 8'hFF);
      rd(8'h64);
      chk_reg("ctrl mask", 32'hF7, rdat);
      rd(8'h60);
      chk_reg("unmapped", 32'h1, {31'h0, rerr});
      show(8'h10);
      chk_pix("pass first", 24'h5A0005, px(5));
      chk_pix("pass last", 24'h5A0302, px(50));
      for (int v = 0; v < 2; v++) begin
         wr(8'h74, 8'(v * 2));
         for (int k = 0; k < 5; k++) begin
            show({4'(k + 1), 4'h1});
            chk_pix("solid", pairs[v][k], px(21));
         end
      end
      wr(8'h74, 8'h00);
      show(8'h01);
      chk_pix("checker even", 24'hFFFFFF, px(0));
      chk_pix("checker odd", 24'h0, px(1));
      chk_pix("checker line", 24'h0, px(16));
      wr(8'h68, 8'h12);
      wr(8'h6C, 8'h34);
      wr(8'h70, 8'h56);
      show(8'hE1);
      chk_pix("custom", 24'h123456, px(9));
      show(8'h15);
      for (int b = 0; b < 4; b++) begin
         chk_pix("bars", barC[b], px(barX[b]));
      end
      for (int r = 0; r < 2; r++) begin
         show(8'hF1 | 8'(r * 2));
         chk_pix("panel top", r ? 24'hFF0000 : 24'hFFFF00,
            px(0) | px(1));
         chk_pix("panel bottom", r ? 24'hFFFF00 : 24'hFF0000,
            px(48) | px(49));
      end
      for (int k = 0; k < 4; k++) begin
         show({4'(k + 6), 4'h1});
         chk_pix("hramp left", 24'h0, px(16));
         chk_pix("hramp mid", masks[k] & 24'h808080, px(24));
         show({4'(k + 10), 4'h1});
         chk_pix("vramp top", 24'h0, px(8));
         chk_pix("vramp mid", masks[k] & 24'h808080, px(37));
      end
      wr(8'h64, 8'h21);
      wr(8'h74, 8'h01);
      rd(8'h78);
      chk_reg("scroll start", 32'h01, rdat);
      frame();
      rd(8'h78);
      chk_reg("scroll step", 32'h11, rdat);
      chk_pix("scroll pixel", 24'hFFFFFF, px(21));
      wr(8'h74, 8'h00);
      rd(8'h78);
      chk_reg("fixed again", 32'h21, rdat);
      finish_test();
   end
endmodule

bind tpc_pattern_ctrl tpc_pattern_ctrl_chk #(.SPAN_W(SPAN_W),
   .SCROLL_FRAMES(SCROLL_FRAMES)) u_chk (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .vidDe(vidDe), .vidHs(vidHs), .vidVs(vidVs), .vidData(vidData),
   .outDe(outDe), .outHs(outHs), .outVs(outVs), .outData(outData));

`default_nettype wire

// ---- verification/tpc_video_sink.sv ----
/*
   Serializer side model: captures the pixels of each frame by position.
   Assumes 16 pixel lines and frames that start at a rising vs.
*/
`timescale 1ns/10ps
`default_nettype none

module tpc_video_sink
   import tpc_pkg::*;
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // video from the block
   input wire logic       de,
   input wire logic       vs,
   input wire tpc_pixel_t data
);
   tpc_pixel_t pix [64];
   int         row;
   int         col;
   logic       deR;
   logic       vsR;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         row <= 0;
         col <= 0;
         deR <= 1'b0;
         vsR <= 1'b0;
      end else begin
         deR <= de;
         vsR <= vs;
         if (vs && !vsR) begin
            row <= 0;
         end else if (!de && deR) begin
            row <= row + 1;
         end
         if (de) begin
            pix[row * 16 + col] <= data;
            col <= col + 1;
         end else begin
            col <= 0;
         end
      end
   end
endmodule

`default_nettype wire
